// file: verilog/dac_host_pkg.sv
// constants, field layout and timing counts for the quad dac latch host
// assumes a single 25 mhz clock; all device pin timing is counted in cycles of it
package dac_host_pkg;

  localparam int CLK_NS = 40;

  // least times round up to whole cycles, never below one cycle
  function automatic int cyc_up(input int t_ns);
    cyc_up = (t_ns + CLK_NS - 1) / CLK_NS;
    if (cyc_up < 1)
      cyc_up = 1;
  endfunction

  // strobe timing, worst case over temperature
  localparam int T_LW_NS = 80;
  localparam int T_CH_NS = 50;
  localparam int T_CW_NS = 100;
  localparam int T_LH_NS = 15;
  localparam int T_LW_MODE_NS = 70;
  localparam int T_CH_MODE_NS = 80;
  localparam int T_ADDR_HOLD_NS = 70;
  localparam int T_RST_NS = 100;

  localparam logic [3:0] LW_CYC = 4'(cyc_up(T_LW_NS));
  localparam logic [3:0] CH_CYC = 4'(cyc_up(T_CH_NS));
  localparam logic [3:0] CW_CYC = 4'(cyc_up(T_CW_NS));
  localparam logic [3:0] LH_CYC = 4'(cyc_up(T_LH_NS));
  localparam logic [3:0] LW_MODE_CYC = 4'(cyc_up(T_LW_MODE_NS));
  localparam logic [3:0] CH_MODE_CYC = 4'(cyc_up(T_CH_MODE_NS));
  localparam logic [3:0] ADDR_HOLD_CYC = 4'(cyc_up(T_ADDR_HOLD_NS));
  localparam logic [3:0] RST_CYC = 4'(cyc_up(T_RST_NS));

  // host register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [5:0] REG_CODE_FIRST = 6'h02;
  localparam logic [5:0] REG_CODE_LAST = 6'h05;
  localparam logic [7:0] REG_MODE = 8'h18;
  localparam logic [7:0] REG_MODE_RANK2 = 8'h1c;
  localparam logic [3:0] REG_RANK2_PAGE = 4'h2;
  localparam logic [3:0] REG_RANK1_PAGE = 4'h3;

  // control and mode fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_CH_LSB = 4;
  localparam int MODE_GAIN_LSB = 4;
  localparam int MODE_POL_LSB = 0;
  localparam int MODE_DATA_LSB = 4;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [1:0] LAST_CH = 2'h3;

  typedef enum logic [2:0] {
    OP_RESET = 3'h0,
    OP_LOAD_UPDATE = 3'h1,
    OP_PRELOAD = 3'h2,
    OP_UPDATE_ALL = 3'h3,
    OP_MODE_UPDATE = 3'h4,
    OP_BATCH_ONE_CS = 3'h5,
    OP_BATCH_SEQ = 3'h6,
    OP_BATCH_PRELOAD = 3'h7
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_CS_LS = 3'h2,
    ST_CS_UP = 3'h3,
    ST_HOLD = 3'h4,
    ST_RST = 3'h5,
    ST_GAP = 3'h6
  } state_t;

endpackage

// file: verilog/phase_timer_if.sv
// carrier between the host sequencer and its phase timer
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface phase_timer_if;
  logic start;
  logic [3:0] count;
  logic done;
  modport ctrl (output start, output count, input done);
  modport timer (input start, input count, output done);
endinterface
`default_nettype wire

// file: verilog/phase_timer.sv
// down counter that times one strobe phase of the host sequencer
// assumes start is a one-cycle pulse and count is at least one
`timescale 1ns/1ps
`default_nettype none
module phase_timer (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // phase request and completion
  phase_timer_if.timer tmr
);
  import dac_host_pkg::*;

  logic [3:0] remain_r;
  logic [3:0] remain_nxt;

  assign remain_nxt = tmr.start ? tmr.count :
                      (remain_r != 4'h0) ? remain_r - 4'h1 : 4'h0;
  // done marks the last cycle of the phase
  assign tmr.done = (remain_r == 4'h1);

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      remain_r <= 4'h0;
    else
      remain_r <= remain_nxt;
  end

  load_count_a: assert property (@(posedge clock_in) disable iff (reset_in)
    tmr.start |=> remain_r == $past(tmr.count))
    else $error("phase timer did not load its count");

endmodule
`default_nettype wire

// file: verilog/dac_latch_host.sv
// host sequencer driving the strobes, address and data of a quad 12-bit dac
// assumes the dac pins are wired straight to these outputs and software
// uses the simple register port; readback and transparent modes are not used
`timescale 1ns/1ps
`default_nettype none
module dac_latch_host #(
  parameter int DATA_W = 12,
  parameter int CHANNELS = 4
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // software register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [31:0] rdata_out,
  // dac strobes, all active low
  output logic chip_select_n_out,
  output logic latch_select_n_out,
  output logic mode_write_n_out,
  output logic pass_through_n_out,
  output logic read_strobe_n_out,
  output logic dac_reset_n_out,
  // dac address and data
  output logic [1:0] channel_addr_out,
  output logic [2:0] nibble_sel_n_out,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_out,
  // status
  output logic busy_out
);
  import dac_host_pkg::*;

  function automatic logic is_preload(input op_t op);
    is_preload = (op == OP_PRELOAD) || (op == OP_BATCH_PRELOAD);
  endfunction

  function automatic logic is_batch(input op_t op);
    is_batch = (op == OP_BATCH_ONE_CS) || (op == OP_BATCH_SEQ) || (op == OP_BATCH_PRELOAD);
  endfunction

  function automatic logic is_seq(input op_t op);
    is_seq = (op == OP_BATCH_SEQ) || (op == OP_BATCH_PRELOAD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  state_t state_r;
  state_t state_nxt;
  op_t op_r;
  op_t op_nxt;
  op_t cmd_op;
  logic [1:0] ch_r;
  logic [1:0] ch_nxt;
  logic [1:0] cmd_ch;
  logic start_r;
  logic start_nxt;
  logic [3:0] count_r;
  logic [3:0] count_nxt;
  logic [7:0] mode_r;
  logic [7:0] mode1_r;
  logic [7:0] mode2_r;
  logic zeroed_r;
  logic [DATA_W-1:0] code_r [CHANNELS];
  logic [DATA_W-1:0] rank1_r [CHANNELS];
  logic [DATA_W-1:0] rank2_r [CHANNELS];
  logic [CHANNELS*DATA_W-1:0] rank1_flat;
  logic [CHANNELS*DATA_W-1:0] rank2_flat;
  logic [31:0] rd_word;
  logic cmd_go;
  logic idle;
  logic cfg_write;
  logic code_hit;
  logic [1:0] code_idx;
  logic [1:0] rd_idx;
  logic cs_low_nxt;
  logic ls_low_nxt;
  logic ms_low_nxt;
  logic drive_nxt;
  logic [DATA_W-1:0] data_nxt;
  logic rank1_load;
  logic rank2_load;
  logic mode1_load;
  logic mode2_load;

  phase_timer_if tmr ();

  phase_timer timer_u (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .tmr(tmr.timer)
  );

  assign tmr.start = start_r;
  assign tmr.count = count_r;

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  assign idle = (state_r == ST_IDLE);
  assign cmd_go = write_in && (addr_in == REG_CTRL) && idle;
  assign cmd_op = op_t'(wdata_in[CTRL_OP_LSB +: 3]);
  assign cmd_ch = wdata_in[CTRL_CH_LSB +: 2];
  // staged codes and mode stay frozen while a transfer drives them onto the pins
  assign cfg_write = write_in && idle;
  assign code_hit = (addr_in[7:2] >= REG_CODE_FIRST) && (addr_in[7:2] <= REG_CODE_LAST)
                    && (addr_in[1:0] == 2'h0);
  assign code_idx = 2'(addr_in[4:2] - 3'h2);
  assign rd_idx = addr_in[3:2];
  assign op_nxt = cmd_go ? cmd_op : op_r;

  ////////////////////////////////////////////////////////////////////////////
  // strobe sequencer

  always_comb
  begin
    state_nxt = state_r;
    ch_nxt = ch_r;
    start_nxt = 1'b0;
    count_nxt = 4'h0;
    case (state_r)
      ST_IDLE:
        if (cmd_go)
        begin
          state_nxt = ST_SETUP;
          ch_nxt = is_batch(cmd_op) ? 2'h0 : cmd_ch;
        end
      ST_SETUP:
      begin
        start_nxt = 1'b1;
        if (op_r == OP_RESET)
        begin
          state_nxt = ST_RST;
          count_nxt = RST_CYC;
        end
        else if (op_r == OP_UPDATE_ALL)
        begin
          state_nxt = ST_CS_UP;
          count_nxt = CW_CYC;
        end
        else
        begin
          state_nxt = ST_CS_LS;
          count_nxt = (op_r == OP_MODE_UPDATE) ? LW_MODE_CYC :
                      is_preload(op_r) ? CW_CYC :
                      (op_r == OP_BATCH_ONE_CS) ? ADDR_HOLD_CYC : LW_CYC;
        end
      end
      ST_CS_LS:
        if (tmr.done)
        begin
          start_nxt = 1'b1;
          if (is_preload(op_r))
          begin
            state_nxt = ST_HOLD;
            count_nxt = LH_CYC;
          end
          else if ((op_r == OP_BATCH_ONE_CS) && (ch_r != LAST_CH))
          begin
            ch_nxt = ch_r + 2'h1;
            count_nxt = ADDR_HOLD_CYC;
          end
          else
          begin
            state_nxt = ST_CS_UP;
            count_nxt = (op_r == OP_MODE_UPDATE) ? CH_MODE_CYC : CH_CYC;
          end
        end
      ST_CS_UP, ST_HOLD, ST_RST:
        if (tmr.done)
          state_nxt = ST_GAP;
      ST_GAP:
        if (is_seq(op_r) && (ch_r != LAST_CH))
        begin
          state_nxt = ST_SETUP;
          ch_nxt = ch_r + 2'h1;
        end
        else
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // pin levels follow the next state so that every pin comes from a flop;
  // ls goes low together with the address, so no lengthening is ever needed
  // ls with address
  assign ls_low_nxt = ((state_nxt == ST_SETUP) && (op_nxt != OP_UPDATE_ALL)
                      && (op_nxt != OP_RESET))
                      || (state_nxt == ST_CS_LS) || (state_nxt == ST_HOLD);
  assign cs_low_nxt = (state_nxt == ST_CS_LS) || (state_nxt == ST_CS_UP);
  assign ms_low_nxt = (op_nxt == OP_MODE_UPDATE) && ((state_nxt == ST_SETUP)
                      || (state_nxt == ST_CS_LS) || (state_nxt == ST_CS_UP));
  assign drive_nxt = (op_nxt != OP_RESET) && ((state_nxt == ST_SETUP)
                     || (state_nxt == ST_CS_LS) || (state_nxt == ST_CS_UP)
                     || (state_nxt == ST_HOLD));
  assign data_nxt = (op_nxt == OP_MODE_UPDATE) ?
                    {mode_r, {MODE_DATA_LSB{1'b0}}} : code_r[ch_nxt];

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_r <= ST_IDLE;
      op_r <= OP_RESET;
      ch_r <= 2'h0;
      start_r <= 1'b0;
      count_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      ch_r <= ch_nxt;
      start_r <= start_nxt;
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      chip_select_n_out <= 1'b1;
      latch_select_n_out <= 1'b1;
      mode_write_n_out <= 1'b1;
      pass_through_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      dac_reset_n_out <= 1'b1;
      channel_addr_out <= 2'h0;
      nibble_sel_n_out <= 3'h7;
      data_out <= CODE_RESET;
      data_oe_out <= 1'b0;
      busy_out <= 1'b0;
    end
    else
    begin
      chip_select_n_out <= !cs_low_nxt;
      latch_select_n_out <= !ls_low_nxt;
      mode_write_n_out <= !ms_low_nxt;
      dac_reset_n_out <= (state_nxt != ST_RST);
      channel_addr_out <= ch_nxt;
      // whole 12-bit words only; all quads are selected while driving
      nibble_sel_n_out <= drive_nxt ? 3'h0 : 3'h7;
      data_out <= data_nxt;
      data_oe_out <= drive_nxt;
      busy_out <= (state_nxt != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mirrors of the device latches

  // first rank at ls phase end
  assign rank1_load = (state_r == ST_CS_LS) && tmr.done && (op_r != OP_MODE_UPDATE);
  assign rank2_load = (state_r == ST_CS_UP) && tmr.done && (op_r != OP_MODE_UPDATE);
  assign mode1_load = (state_r == ST_CS_LS) && tmr.done && (op_r == OP_MODE_UPDATE);
  assign mode2_load = (state_r == ST_CS_UP) && tmr.done && (op_r == OP_MODE_UPDATE);

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : chan_g
      always_ff @(posedge clock_in or posedge reset_in)
      begin
        if (reset_in)
        begin
          code_r[gi] <= CODE_RESET;
          rank1_r[gi] <= CODE_RESET;
          rank2_r[gi] <= CODE_RESET;
        end
        else
        begin
          if (cfg_write && code_hit && (code_idx == 2'(gi)))
            code_r[gi] <= wdata_in[DATA_W-1:0];
          if (rank1_load && (ch_r == 2'(gi)))
            rank1_r[gi] <= code_r[gi];
          if (rank2_load)
            rank2_r[gi] <= rank1_r[gi];
        end
      end
      assign rank1_flat[gi*DATA_W +: DATA_W] = rank1_r[gi];
      assign rank2_flat[gi*DATA_W +: DATA_W] = rank2_r[gi];
    end
  endgenerate

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      mode_r <= MODE_RESET;
      mode1_r <= MODE_RESET;
      mode2_r <= MODE_RESET;
      zeroed_r <= 1'b0;
    end
    else
    begin
      if (cfg_write && (addr_in == REG_MODE))
        mode_r <= wdata_in[7:0];
      if (mode1_load)
        mode1_r <= mode_r;
      if (mode2_load)
        mode2_r <= mode1_r;
      // outputs held at zero until the next second-rank update
      if ((state_r == ST_RST) && tmr.done)
        zeroed_r <= 1'b1;
      else if (rank2_load)
        zeroed_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  // bit one gives gain two or unipolar
  assign rd_word = (addr_in == REG_CTRL) ? {24'h0, 2'h0, ch_r, 1'b0, op_r} :
                   (addr_in == REG_STATUS) ? {30'h0, zeroed_r, busy_out} :
                   code_hit ? {20'h0, code_r[code_idx]} :
                   (addr_in == REG_MODE) ? {24'h0, mode_r} :
                   (addr_in == REG_MODE_RANK2) ?
                     {16'h0, 4'h0, mode2_r[MODE_GAIN_LSB +: 4], 4'h0, mode2_r[MODE_POL_LSB +: 4]} :
                   ((addr_in[7:4] == REG_RANK2_PAGE) && (addr_in[1:0] == 2'h0)) ?
                     {20'h0, rank2_r[rd_idx]} :
                   ((addr_in[7:4] == REG_RANK1_PAGE) && (addr_in[1:0] == 2'h0)) ?
                     {20'h0, rank1_r[rd_idx]} : 32'h0;

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      rdata_out <= 32'h0;
    else
      rdata_out <= read_in ? rd_word : 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on the pin sequences

  preload_order_a: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(chip_select_n_out) && is_preload(op_r) |-> !latch_select_n_out)
    else $error("cs did not rise before ls in a preload");

  preload_hold_a: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(chip_select_n_out) && is_preload(op_r) |=> !latch_select_n_out
      && $stable(data_out) && $stable(channel_addr_out))
    else $error("preload hold after cs too short");

  preload_width_a: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(chip_select_n_out) && is_preload(op_r) |-> (!chip_select_n_out)[*3])
    else $error("preload cs pulse too short");

  ls_width_a: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(chip_select_n_out) && (op_r == OP_LOAD_UPDATE) |-> (!latch_select_n_out)[*2])
    else $error("ls low pulse too short");

  cs_after_ls_a: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(latch_select_n_out) && !chip_select_n_out |-> (!chip_select_n_out)[*2])
    else $error("cs released too soon after ls");

  update_strobes_a: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(chip_select_n_out) && (op_r == OP_UPDATE_ALL) |-> (latch_select_n_out
      && mode_write_n_out && pass_through_n_out && read_strobe_n_out && dac_reset_n_out)[*3])
    else $error("global update with a strobe low");

  rank1_intact_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (op_r == OP_UPDATE_ALL) && !idle |=> $stable(rank1_flat))
    else $error("first rank changed during global update");

  preload_no_out_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (op_r == OP_BATCH_PRELOAD) && !idle |=> $stable(rank2_flat))
    else $error("second rank changed during preload");

  ls_before_cs_a: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(chip_select_n_out) && ((op_r == OP_BATCH_ONE_CS) || (op_r == OP_BATCH_SEQ))
      |-> $past(latch_select_n_out))
    else $error("ls still low when cs rose");

  mode_word_a: assert property (@(posedge clock_in) disable iff (reset_in)
    !mode_write_n_out && data_oe_out |-> (data_out[3:0] == 4'h0) && (data_out[11:4] == mode_r))
    else $error("mode word misplaced on data pins");

  mode_entry_a: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(chip_select_n_out) && (op_r == OP_MODE_UPDATE) |-> !$past(mode_write_n_out)
      && !$past(latch_select_n_out) && !mode_write_n_out)
    else $error("mode strobes not set before cs");

  busy_bound_a: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(busy_out) |-> ##[1:60] !busy_out)
    else $error("transfer did not finish in time");

endmodule
`default_nettype wire

// file: tb/quad_dac_model.sv
// device model: quad dac input latches, mode latches, reset flag
// assumes its pins come straight from the host sequencer; no clock
`timescale 1ns/1ps
`default_nettype none
module quad_dac_model (
  // strobes, active low
  input wire logic cs_n_in,
  input wire logic latch_select_n_in,
  input wire logic mode_write_n_in,
  input wire logic pass_through_n_in,
  input wire logic rd_n_in,
  input wire logic rst_n_in,
  // address and data pins
  input wire logic [1:0] ch_in,
  input wire logic [2:0] nib_n_in,
  input wire logic [11:0] data_in,
  input wire logic oe_in,
  // latch contents and timing faults seen
  output logic [3:0][11:0] rank1_out,
  output logic [3:0][11:0] rank2_out,
  output logic [7:0] mode1_out,
  output logic [7:0] mode2_out,
  output logic zeroed_out,
  output logic [7:0] faults_out
);
  logic [11:0] last_r;
  logic [11:0] pins;
  logic mode_c;
  realtime t_lf = 0;
  realtime t_cf = 0;
  realtime t_lr = 0;
  realtime t_cr = 0;
  ////////////////////////////////////////////////////////////////////////////
  // released bus shows the inverse of the last driven word, not a stale copy
  assign pins = oe_in ? data_in : ~last_r;
  always @(data_in or oe_in)
    if (oe_in)
      last_r = data_in;
  initial
    {rank1_out, rank2_out, mode1_out, mode2_out, zeroed_out, faults_out} = '0;
  task automatic bump();
    faults_out = faults_out + 8'h01;
  endtask
  always @(cs_n_in or latch_select_n_in or mode_write_n_in or pins or ch_in or nib_n_in)
    if (!cs_n_in && !latch_select_n_in && pass_through_n_in && rd_n_in)
    begin
      if (mode_write_n_in && nib_n_in == 3'h0)
        rank1_out[ch_in] = pins;
      else if (!mode_write_n_in && nib_n_in[1:0] == 2'h0)
        mode1_out = pins[11:4];
    end
  task automatic xfer();
    if (mode_c)
    begin
      rank2_out = rank1_out;
      zeroed_out = 1'b0;
    end
    else
      mode2_out = mode1_out;
  endtask
  always @(negedge rst_n_in)
    zeroed_out = 1'b1;
  always @(negedge latch_select_n_in)
    t_lf = $realtime;
  always @(negedge cs_n_in)
  begin
    t_cf = $realtime;
    mode_c = mode_write_n_in;
  end
  // latch width
  // edges out of an unknown power-up level are not strobes
  always @(posedge latch_select_n_in)
    if (t_lf > 0)
    begin
      t_lr = $realtime;
      if (!cs_n_in)
      begin
        xfer();
        if (t_lr - t_lf < (mode_c ? 80 : 70))
          bump();
      end
      else if (t_lr - t_cr < 15)
        bump();
    end
  always @(posedge cs_n_in)
    if (t_cf > 0)
    begin
      t_cr = $realtime;
      if (latch_select_n_in && pass_through_n_in && rd_n_in)
      begin
        xfer();
        if (t_lr > t_cf && t_cr - t_lr < (mode_c ? 50 : 80))
          bump();
      end
      else if (t_cr - t_cf < 100)
        bump();
    end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the dac latch host against the device model
// assumes host pins wire straight to the model; one 25 mhz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dac_host_pkg::*;
  typedef struct packed {logic [1:0] ch; logic [11:0] code;} row_t;
  logic clock_in, reset_in, write_in, read_in;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, v;
  logic cs_n, latch_n, mode_n, pass_n, rd_n, rst_n, oe, busy, zeroed;
  logic [1:0] ch_addr;
  logic [2:0] nib_n;
  logic [11:0] data;
  logic [3:0][11:0] r1, r2, exp1, exp2;
  logic [7:0] m1, m2, faults;
  int errors, samples_checked, cycles;
  row_t rows [4] = '{'{2'h0, 12'h123}, '{2'h1, 12'hfff}, '{2'h2, 12'h800}, '{2'h3, 12'h5a5}};
  logic [7:0] modes [2] = '{8'ha6, 8'h59};
  dac_latch_host uut (.clock_in(clock_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
    .chip_select_n_out(cs_n), .latch_select_n_out(latch_n), .mode_write_n_out(mode_n),
    .pass_through_n_out(pass_n), .read_strobe_n_out(rd_n), .dac_reset_n_out(rst_n),
    .channel_addr_out(ch_addr), .nibble_sel_n_out(nib_n), .data_out(data),
    .data_oe_out(oe), .busy_out(busy));
  quad_dac_model dev (.cs_n_in(cs_n), .latch_select_n_in(latch_n), .mode_write_n_in(mode_n),
    .pass_through_n_in(pass_n), .rd_n_in(rd_n), .rst_n_in(rst_n), .ch_in(ch_addr),
    .nib_n_in(nib_n), .data_in(data), .oe_in(oe), .rank1_out(r1), .rank2_out(r2),
    .mode1_out(m1), .mode2_out(m2), .zeroed_out(zeroed), .faults_out(faults));
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d, mismatched %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a whole run is well under two thousand cycles
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      errors++;
      $display("unexpected at %0t: run too long", $time);
      conclude();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    #1;
    while (busy === 1'b1 && n < 300)
    begin
      @(posedge clock_in);
      #1 n++;
    end
    chk(32'(busy), 32'h0);
  endtask
  task automatic run(input logic [2:0] op, input logic [1:0] ch);
    wr(REG_CTRL, {26'h0, ch, 1'b0, op});
    wait_idle();
  endtask
  task automatic stage(input logic [3:0][11:0] codes);
    for (int c = 0; c < 4; c++)
      wr({REG_CODE_FIRST + 6'(c), 2'h0}, 32'(codes[c]));
    exp1 = codes;
  endtask
  task automatic check_all();
    for (int c = 0; c < 4; c++)
    begin
      chk(32'(r1[c]), 32'(exp1[c]));
      chk(32'(r2[c]), 32'(exp2[c]));
      rd({REG_RANK1_PAGE, 2'(c), 2'h0}, v);
      chk(v, 32'(exp1[c]));
      rd({REG_RANK2_PAGE, 2'(c), 2'h0}, v);
      chk(v, 32'(exp2[c]));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {reset_in, addr_in, wdata_in, write_in, read_in} = {1'b1, 42'h0};
    {errors, samples_checked, cycles, exp1, exp2} = '0;
    repeat (5) @(posedge clock_in);
    reset_in <= 1'b0;
    #1 chk({21'h0, cs_n, latch_n, mode_n, pass_n, rd_n, rst_n, nib_n, oe, busy}, 32'h7fc);
    rd(REG_STATUS, v);
    chk(v, 32'h0);
    rd(8'h40, v);
    chk(v, 32'h0);
    @(posedge clock_in);
    #1 chk(rdata_out, 32'h0);
    foreach (rows[i])
    begin
      wr({REG_CODE_FIRST + 6'(rows[i].ch), 2'h0}, 32'(rows[i].code));
      run(OP_LOAD_UPDATE, rows[i].ch);
      exp1[rows[i].ch] = rows[i].code;
      exp2 = exp1;
      check_all();
    end
    wr({REG_CODE_FIRST + 6'h1, 2'h0}, 32'h3c3);
    run(OP_PRELOAD, 2'h1);
    exp1[1] = 12'h3c3;
    check_all();
    // code write while busy must be dropped
    wr(REG_CTRL, {26'h0, 2'h1, 1'b0, OP_PRELOAD});
    wr({REG_CODE_FIRST + 6'h1, 2'h0}, 32'h999);
    wait_idle();
    rd({REG_CODE_FIRST + 6'h1, 2'h0}, v);
    chk(v, 32'h3c3);
    // read data stands for one cycle only
    @(posedge clock_in);
    #1 chk(rdata_out, 32'h0);
    stage(48'h0a1_0b2_0c3_0d4);
    run(OP_BATCH_PRELOAD, 2'h0);
    check_all();
    run(OP_UPDATE_ALL, 2'h2);
    exp2 = exp1;
    check_all();
    run(OP_RESET, 2'h0);
    chk(32'(zeroed), 32'h1);
    rd(REG_STATUS, v);
    chk(v, 32'h2);
    stage(48'h321_654_987_cba);
    run(OP_BATCH_SEQ, 2'h0);
    exp2 = exp1;
    check_all();
    chk(32'(zeroed), 32'h0);
    stage(48'hfed_012_edc_123);
    run(OP_BATCH_ONE_CS, 2'h0);
    exp2 = exp1;
    check_all();
    foreach (modes[i])
    begin
      wr(REG_MODE, 32'(modes[i]));
      run(OP_MODE_UPDATE, 2'h0);
      chk(32'(m2), 32'(modes[i]));
      rd(REG_MODE_RANK2, v);
      chk(v, {20'h0, modes[i][7:4], 4'h0, modes[i][3:0]});
    end
    chk(32'(r2), 32'(exp2));
    chk(32'(faults), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
